// file: rtl/dbag_top.sv
// Data RAM bank address generator: bank select register, access bank
// mapping, memory-to-memory moves and the data RAM itself.
// Assumes the instruction decoder holds op_* until op_ready takes it, op_dst_addr one cycle longer,
// and an APB master on the same pclk for the register port.
//
// Function
// R1: sixteen banks of 256 bytes, all SRAM
// R2: banked address is bank nibble then field
// R3: bank select upper nibble reads zero, unwritable
// R4: access bit 0 selects access bank
// R5: access bank is bank0 low, bank15 high
// R6: access window is contiguous across the seam
// R7: special registers reachable whatever bank is set
// R8: unimplemented bank reads zero, drops writes
// R9: move uses full embedded addresses, no bank
// R10: bank load instruction writes bank select
// R11: reset clears bank select to zero
`timescale 1ns/1ps
module dbag_top #(
	parameter logic [15:0] IMPL_BANKS = 16'hffff
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        op_valid,
	input  wire logic [1:0]  op_kind,
	input  wire logic        op_access,
	input  wire logic [7:0]  op_field,
	input  wire logic [7:0]  op_literal,
	input  wire logic [7:0]  op_wdata,
	input  wire logic [11:0] op_src_addr,
	input  wire logic [11:0] op_dst_addr,
	output logic             op_ready,
	output logic             op_done,
	output logic      [7:0]  op_rdata,
	output logic             op_zero,
	output logic      [11:0] data_addr,
	output logic             sfr_hit,
	output logic      [7:0]  bank_select
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dbag_pkg::dbag_state_type state_reg;
	dbag_pkg::dbag_state_type state_next;

	logic [7:0]  bank_select_reg;
	logic [7:0]  bank_select_next;
	logic        ready_reg;
	logic        done_reg;
	logic        done_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        zero_reg;
	logic        zero_next;
	logic [11:0] addr_reg;
	logic        sfr_reg;
	logic        impl_q_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;

	logic        taken;
	logic        take_read;
	logic        take_write;
	logic        take_load;
	logic        take_move;
	logic        map_full;
	logic [11:0] map_full_addr;
	logic [11:0] map_addr;
	logic        map_impl;
	logic        map_sfr;
	logic        ram_we;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_q;
	logic [7:0]  read_value;
	logic        addr_sel_bank;
	logic        addr_sel_status;
	logic        addr_mapped;
	logic        apb_setup;
	logic        apb_access;
	logic        apb_bank_write;
	logic [31:0] status_word;
	logic [31:0] apb_read_value;

	// ----------------------------------------------------------------
	// Operation decode
	// ----------------------------------------------------------------
	// An operation is taken only while the sequencer is idle
	assign taken      = op_valid && ready_reg;
	assign take_read  = taken && (op_kind == dbag_pkg::OP_READ);
	assign take_write = taken && (op_kind == dbag_pkg::OP_WRITE);
	assign take_load  = taken && (op_kind == dbag_pkg::OP_BANK_LOAD);
	assign take_move  = taken && (op_kind == dbag_pkg::OP_MEM_MOVE);

	// ----------------------------------------------------------------
	// Address mapping and data RAM
	// ----------------------------------------------------------------
	// Moves bypass bank select: source first, destination one cycle on
	assign map_full      = take_move || (state_reg == dbag_pkg::ST_MV_WAIT); // see R9
	assign map_full_addr = (state_reg == dbag_pkg::ST_MV_WAIT) ? op_dst_addr : op_src_addr;

	dbag_map #(
		.IMPL_BANKS (IMPL_BANKS)
	) u_map (
		.access_sel  (op_access),
		.bank        (bank_select_reg[3:0]),
		.field       (op_field),
		.full_addr   (map_full_addr),
		.use_full    (map_full),
		.addr        (map_addr),
		.implemented (map_impl),
		.sfr_hit     (map_sfr)
	); // see R2, R4, R5, R6, R7

	// Writes to a missing bank never reach the array
	assign ram_we    = map_impl && (take_write || (state_reg == dbag_pkg::ST_MV_WAIT)); // see R8
	assign ram_wdata = (state_reg == dbag_pkg::ST_MV_WAIT) ? read_value : op_wdata;

	dbag_ram #(
		.ADDR_W (dbag_pkg::DATA_ADDR_W),
		.DATA_W (8)
	) u_ram (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (ram_we),
		.addr    (map_addr),
		.wdata   (ram_wdata),
		.rdata   (ram_q)
	); // see R1

	// Missing bank reads as zero; the flag still follows the value
	assign read_value = impl_q_reg ? ram_q : dbag_pkg::CORE_DATA_RESET; // see R8

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Reads and moves need one extra cycle for the registered RAM
	always_comb
	begin
		state_next = state_reg;
		done_next  = 1'b0;
		rdata_next = rdata_reg;
		zero_next  = zero_reg;
		case (state_reg)
			dbag_pkg::ST_IDLE:
			begin
				if (take_read)
					state_next = dbag_pkg::ST_RD_WAIT;
				else if (take_move)
					state_next = dbag_pkg::ST_MV_WAIT;
				else if (take_write || take_load)
					done_next = 1'b1;
			end
			dbag_pkg::ST_RD_WAIT:
			begin
				state_next = dbag_pkg::ST_IDLE;
				done_next  = 1'b1;
				rdata_next = read_value;
				zero_next  = (read_value == 8'h00); // see R8
			end
			dbag_pkg::ST_MV_WAIT:
			begin
				state_next = dbag_pkg::ST_IDLE;
				done_next  = 1'b1;
				rdata_next = read_value;
			end
			default:
				state_next = dbag_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= dbag_pkg::ST_IDLE;
			ready_reg <= 1'b0;
			done_reg  <= 1'b0;
			rdata_reg <= dbag_pkg::CORE_DATA_RESET;
			zero_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ready_reg <= (state_next == dbag_pkg::ST_IDLE);
			done_reg  <= done_next;
			rdata_reg <= rdata_next;
			zero_reg  <= zero_next;
		end
	end

	// Address bookkeeping for the core and the status word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_reg   <= dbag_pkg::DATA_ADDR_RESET;
			sfr_reg    <= 1'b0;
			impl_q_reg <= 1'b0;
		end
		else if (taken && !take_load)
		begin
			addr_reg   <= map_addr;
			sfr_reg    <= map_sfr;
			impl_q_reg <= map_impl;
		end
	end

	// ----------------------------------------------------------------
	// Bank select register
	// ----------------------------------------------------------------
	// The instruction wins over a same-cycle APB write; core owns it
	assign bank_select_next = take_load ? {4'h0, op_literal[3:0]} // see R10
		: apb_bank_write ? {4'h0, pwdata[3:0]}                    // see R3
		: bank_select_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bank_select_reg <= dbag_pkg::BANK_SELECT_RESET; // see R11
		else
			bank_select_reg <= bank_select_next;
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// No wait states: pready rises in the first access cycle
	assign apb_setup       = psel && !penable;
	assign apb_access      = psel && penable && pready_reg;
	assign addr_sel_bank   = (paddr == dbag_pkg::BANK_SELECT_OFFSET);
	assign addr_sel_status = (paddr == dbag_pkg::STATUS_OFFSET);
	assign addr_mapped     = addr_sel_bank || addr_sel_status;
	assign apb_bank_write  = apb_access && pwrite && addr_sel_bank;

	assign status_word = {14'h0000, sfr_reg, (state_reg != dbag_pkg::ST_IDLE), 4'h0, addr_reg};
	assign apb_read_value = addr_sel_bank ? {24'h000000, bank_select_reg}
		: addr_sel_status ? status_word
		: 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= apb_setup;
			pslverr_reg <= apb_setup && !addr_mapped;
			prdata_reg  <= (apb_setup && !pwrite) ? apb_read_value : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign op_ready    = ready_reg;
	assign op_done     = done_reg;
	assign op_rdata    = rdata_reg;
	assign op_zero     = zero_reg;
	assign data_addr   = addr_reg;
	assign sfr_hit     = sfr_reg;
	assign bank_select = bank_select_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_bank_upper_zero: assert property ( // see R3
		@(posedge pclk) disable iff (!presetn)
		bank_select_reg[7:4] == 4'h0)
		else $error("bank select upper nibble not zero");

	a_banked_addr_form: assert property ( // see R2
		@(posedge pclk) disable iff (!presetn)
		(take_read || take_write) && op_access
		|=> data_addr == {$past(bank_select_reg[3:0]), $past(op_field)})
		else $error("banked address not bank nibble plus field");

	a_access_low_map: assert property ( // see R5
		@(posedge pclk) disable iff (!presetn)
		(take_read || take_write) && !op_access && (op_field < 8'h60)
		|=> data_addr == {4'h0, $past(op_field)} && !sfr_hit)
		else $error("access low part not in bank 0");

	a_access_high_map: assert property ( // see R6
		@(posedge pclk) disable iff (!presetn)
		(take_read || take_write) && !op_access && (op_field >= 8'h60)
		|=> data_addr == {4'hf, $past(op_field)} && sfr_hit)
		else $error("access high part not in bank 15");

	a_sfr_any_bank: assert property ( // see R7
		@(posedge pclk) disable iff (!presetn)
		take_read && !op_access && (op_field == 8'hff)
		|=> data_addr == 12'hfff ##1 op_done)
		else $error("special register unreachable through access bank");

	a_unimpl_read_zero: assert property ( // see R8
		@(posedge pclk) disable iff (!presetn)
		take_read && !map_impl |-> ##2 op_done && op_rdata == 8'h00 && op_zero)
		else $error("missing bank read not zero");

	a_unimpl_write_drop: assert property ( // see R8
		@(posedge pclk) disable iff (!presetn)
		!map_impl |-> !ram_we)
		else $error("write reached a missing bank");

	a_move_full_addr: assert property ( // see R9
		@(posedge pclk) disable iff (!presetn)
		take_move |-> map_addr == op_src_addr
		##1 map_addr == op_dst_addr && state_reg == dbag_pkg::ST_MV_WAIT
		##1 op_done && op_ready)
		else $error("move did not use embedded addresses");

	a_bank_load_write: assert property ( // see R10
		@(posedge pclk) disable iff (!presetn)
		take_load |=> bank_select == {4'h0, $past(op_literal[3:0])} && op_done)
		else $error("bank load did not set bank select");

	a_apb_bank_write: assert property ( // see R3
		@(posedge pclk) disable iff (!presetn)
		apb_bank_write && !take_load
		|=> bank_select_reg == {4'h0, $past(pwdata[3:0])})
		else $error("APB write to bank select mishandled");

	a_reset_bank_zero: assert property ( // see R11
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> bank_select_reg == 8'h00)
		else $error("bank select not zero after reset");

endmodule

// file: rtl/dbag_pkg.sv
// Constants and types shared by the data RAM bank address generator.
// Assumes one clock (pclk) and an active-low asynchronous reset.
package dbag_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte offsets)
	// ----------------------------------------------------------------
	localparam logic [11:0] BANK_SELECT_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET      = 12'h004;
	localparam logic [7:0]  BANK_SELECT_RESET  = 8'h00;
	localparam int          BANK_FIELD_LSB     = 0;
	localparam int          BANK_FIELD_W       = 4;
	localparam int          STATUS_ADDR_LSB    = 0;
	localparam int          STATUS_BUSY_BIT    = 16;
	localparam int          STATUS_SFR_BIT     = 17;

	// ----------------------------------------------------------------
	// Data memory geometry
	// ----------------------------------------------------------------
	localparam int          DATA_ADDR_W      = 12;
	localparam int          NUM_BANKS        = 16;
	localparam logic [7:0]  ACCESS_LOW_SIZE  = 8'h60;
	localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
	localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hf;
	localparam logic [7:0]  CORE_DATA_RESET  = 8'h00;
	localparam logic [11:0] DATA_ADDR_RESET  = 12'h000;

	// ----------------------------------------------------------------
	// Core operation codes and sequencer states
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_READ      = 2'h0;
	localparam logic [1:0] OP_WRITE     = 2'h1;
	localparam logic [1:0] OP_BANK_LOAD = 2'h2;
	localparam logic [1:0] OP_MEM_MOVE  = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_MV_WAIT
	} dbag_state_type;

endpackage

// file: rtl/dbag_ram.sv
// Byte-wide static data RAM, one word per data address.
// Assumes the caller decodes unimplemented banks; read data is registered.
`timescale 1ns/1ps
module dbag_ram #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rdata_reg;

	// Array has no reset, as a real SRAM would not
	always_ff @(posedge pclk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	// Registered read port, old data on a same-address write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_reg <= '0;
		else
			rdata_reg <= mem[addr];
	end

	assign rdata = rdata_reg;

endmodule

// file: rtl/dbag_map.sv
// Direct address mapper: banked or access bank, plus region decode.
// Assumes purely combinational use inside the generator top.
`timescale 1ns/1ps
module dbag_map #(
	parameter logic [15:0] IMPL_BANKS = 16'hffff
) (
	input  wire logic        access_sel,
	input  wire logic [3:0]  bank,
	input  wire logic [7:0]  field,
	input  wire logic [11:0] full_addr,
	input  wire logic        use_full,
	output logic      [11:0] addr,
	output logic             implemented,
	output logic             sfr_hit
);

	// ----------------------------------------------------------------
	// Mapping
	// ----------------------------------------------------------------
	logic        low_part;
	logic [3:0]  access_bank;
	logic [11:0] direct_addr;

	// Low part first, then the top of the last bank: one flat window
	assign low_part    = (field < dbag_pkg::ACCESS_LOW_SIZE);
	assign access_bank = low_part ? dbag_pkg::ACCESS_LOW_BANK : dbag_pkg::ACCESS_HIGH_BANK;
	assign direct_addr = access_sel ? {bank, field} : {access_bank, field};
	assign addr        = use_full ? full_addr : direct_addr;

	// Region decode on the final address
	assign implemented = IMPL_BANKS[addr[11:8]];
	assign sfr_hit     = (addr[11:8] == dbag_pkg::ACCESS_HIGH_BANK)
		&& (addr[7:0] >= dbag_pkg::ACCESS_LOW_SIZE);

endmodule

// file: bench/dbag_dec_model.sv
// Instruction decoder model: presents one core operation at a time.
// Assumes the generator's pclk and its registered op_ready and op_done.
`timescale 1ns/1ps
module dbag_dec_model (
	input  wire logic        pclk,
	input  wire logic        op_ready,
	input  wire logic        op_done,
	output logic             op_valid,
	output logic      [1:0]  op_kind,
	output logic             op_access,
	output logic      [7:0]  op_field,
	output logic      [7:0]  op_literal,
	output logic      [7:0]  op_wdata,
	output logic      [11:0] op_src_addr,
	output logic      [11:0] op_dst_addr
);
	// ----------------------------------------------------------------
	// Idle levels at time zero
	// ----------------------------------------------------------------
	initial
	begin
		op_valid = 1'b0;
		op_kind = 2'h0;
		op_access = 1'b0;
		op_field = 8'h00;
		op_literal = 8'h00;
		op_wdata = 8'h00;
		op_src_addr = 12'h000;
		op_dst_addr = 12'h000;
	end

	// ----------------------------------------------------------------
	// One operation: hold until taken, then wait for completion
	// ----------------------------------------------------------------
	task automatic issue(input logic [1:0] k, input logic a, input logic [7:0] f, l, w,
		input logic [11:0] s, d, output bit ok);
		int i;
		ok = 1'b0;
		@(posedge pclk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_access <= a;
		op_field <= f;
		op_literal <= l;
		op_wdata <= w;
		op_src_addr <= s;
		op_dst_addr <= d;
		// op_ready is registered, so mid-cycle sampling is race free
		for (i = 0; i < 20 && !ok; i++)
		begin
			@(negedge pclk);
			ok = (op_ready === 1'b1);
		end
		if (ok)
		begin
			@(posedge pclk);
			// Released fields flip so stale values never pass for live ones
			op_valid <= 1'b0;
			op_kind <= ~k;
			op_access <= ~a;
			op_field <= ~f;
			op_literal <= ~l;
			op_wdata <= ~w;
			op_src_addr <= ~s;
			ok = 1'b0;
			for (i = 0; i < 20 && !ok; i++)
			begin
				@(negedge pclk);
				ok = (op_done === 1'b1);
			end
			@(posedge pclk);
			op_dst_addr <= ~d; // Destination held past the take edge
		end
	endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the bank address generator, bank 1 missing.
// Assumes the decoder model drives the core port and APB comes from here.
`timescale 1ns/1ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, data_addr, op_src_addr, op_dst_addr;
	logic [31:0] pwdata, prdata, rd;
	logic        op_valid, op_access, op_ready, op_done, op_zero, sfr_hit, er;
	logic [1:0]  op_kind;
	logic [7:0]  op_field, op_literal, op_wdata, op_rdata, bank_select;
	int          error_cnt, check_count, n;

	dbag_top #(.IMPL_BANKS(16'hfffd)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_kind, .op_access,
		.op_field, .op_literal, .op_wdata, .op_src_addr, .op_dst_addr, .op_ready,
		.op_done, .op_rdata, .op_zero, .data_addr, .sfr_hit, .bank_select);
	dbag_dec_model dec (.pclk, .op_ready, .op_done, .op_valid, .op_kind, .op_access,
		.op_field, .op_literal, .op_wdata, .op_src_addr, .op_dst_addr);

	// ----------------------------------------------------------------
	// Clock, checks and closing report
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic test_done;
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, exp, input string msg);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// Bus and core access tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		bit ok;
		ok = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Request held until pready is seen high at a rising edge; answer taken there
		for (i = 0; i < 20 && !ok; i++)
		begin
			@(posedge pclk);
			ok = (pready === 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (!ok)
			check(0, 1, "bus timeout");
		if (!ok)
			test_done;
	endtask

	task automatic op(input logic [1:0] k, input logic a, input logic [7:0] f, l, w,
		input logic [11:0] s, d);
		bit ok;
		dec.issue(k, a, f, l, w, s, d, ok);
		if (!ok)
			check(0, 1, "core timeout");
		if (!ok)
			test_done;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		error_cnt = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(bank_select, 32'h0, "reset bank");
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0, "reset read");
		apb(1'b1, 12'h000, 32'hffff_ffa5);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h5, "upper nibble read");
		op(dbag_pkg::OP_READ, 1'b1, 8'h01, 8'h00, 8'h00, 12'h0, 12'h0);
		check(data_addr, 32'h501, "bus set bank");
		apb(1'b0, 12'h008, 32'h0);
		check(er, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		// Load each bank in turn and write one byte into it
		for (n = 0; n < 16; n++)
		begin
			op(dbag_pkg::OP_BANK_LOAD, 1'b1, 8'h00, {4'hc, 4'(n)}, 8'h00, 12'h0, 12'h0);
			check(bank_select, 32'(n), "bank load");
			op(dbag_pkg::OP_WRITE, 1'b1, 8'(n * 17), 8'h00, 8'(n) ^ 8'h5a, 12'h0, 12'h0);
			check(data_addr, 32'(n * 256 + n * 17), "banked addr");
		end
		// Missing bank reads zero and sets the zero flag
		for (n = 0; n < 16; n++)
		begin
			op(dbag_pkg::OP_BANK_LOAD, 1'b1, 8'h00, 8'(n), 8'h00, 12'h0, 12'h0);
			op(dbag_pkg::OP_READ, 1'b1, 8'(n * 17), 8'h00, 8'h00, 12'h0, 12'h0);
			check(op_rdata, (n == 1) ? 32'h0 : 32'(8'(n) ^ 8'h5a), "read back");
			check(op_zero, 32'(n == 1), "zero flag");
		end
		// Access bank seam with an unrelated bank selected
		op(dbag_pkg::OP_BANK_LOAD, 1'b1, 8'h00, 8'h03, 8'h00, 12'h0, 12'h0);
		op(dbag_pkg::OP_WRITE, 1'b0, 8'h5f, 8'h00, 8'h11, 12'h0, 12'h0);
		check(data_addr, 32'h05f, "access low end");
		op(dbag_pkg::OP_WRITE, 1'b0, 8'h60, 8'h00, 8'h22, 12'h0, 12'h0);
		check(data_addr, 32'hf60, "access high start");
		check(sfr_hit, 32'h1, "special region");
		op(dbag_pkg::OP_READ, 1'b1, 8'h5f, 8'h00, 8'h00, 12'h0, 12'h0);
		check(sfr_hit, 32'h0, "banked not special");
		op(dbag_pkg::OP_BANK_LOAD, 1'b1, 8'h00, 8'h0f, 8'h00, 12'h0, 12'h0);
		op(dbag_pkg::OP_READ, 1'b1, 8'h60, 8'h00, 8'h00, 12'h0, 12'h0);
		check(op_rdata, 32'h22, "bank 15 via access");
		op(dbag_pkg::OP_READ, 1'b0, 8'h5f, 8'h00, 8'h00, 12'h0, 12'h0);
		check(op_rdata, 32'h11, "bank 0 via access");
		// Moves ignore the bank select register
		op(dbag_pkg::OP_MEM_MOVE, 1'b1, 8'h00, 8'h00, 8'h00, 12'h222, 12'h7aa);
		check(op_rdata, 32'h58, "move data");
		check(data_addr, 32'h222, "move source");
		op(dbag_pkg::OP_BANK_LOAD, 1'b1, 8'h00, 8'h07, 8'h00, 12'h0, 12'h0);
		op(dbag_pkg::OP_READ, 1'b1, 8'haa, 8'h00, 8'h00, 12'h0, 12'h0);
		check(op_rdata, 32'h58, "move landed");
		// Reset in mid-run: bank select back to zero, array keeps its contents
		check(bank_select, 32'h7, "bank before reset");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(bank_select, 32'h0, "mid-run reset bank");
		// Top of the special region through the access bank
		op(dbag_pkg::OP_READ, 1'b0, 8'hff, 8'h00, 8'h00, 12'h0, 12'h0);
		check(data_addr, 32'hfff, "special top addr");
		check(sfr_hit, 32'h1, "special top hit");
		check(op_rdata, 32'h55, "special top data");
		op(dbag_pkg::OP_MEM_MOVE, 1'b1, 8'h00, 8'h00, 8'h00, 12'h111, 12'h7ab);
		check(op_rdata, 32'h0, "move from missing");
		// Status word: last source address, idle, not special
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0000_0111, "status word");
		check(er, 32'h0, "status no error");
		test_done;
	end
endmodule
